// *** include/image_window_defs.svh ***
`ifndef IMAGE_WINDOW_DEFS_SVH
`define IMAGE_WINDOW_DEFS_SVH

// Geometry and stream widths
`define DIM_W            16
`define PIX_W            12
`define STAGE_NUM        8
`define TRIM_W           4

// Effective sensor array; values are build constants of this device
`define SENSOR_COLS      16'h0400
`define SENSOR_ROWS      16'h0200

// Window granularity and minimum size
`define WIDTH_ALIGN_MSB  4
`define HEIGHT_ALIGN_MSB 2
`define MIN_WIDTH        16'h0040
`define MIN_HEIGHT       16'h0010

// Register byte offsets
`define OFF_CTRL         8'h00
`define OFF_WIDTH        8'h04
`define OFF_HEIGHT       8'h08
`define OFF_HSTART       8'h0c
`define OFF_VSTART       8'h10
`define OFF_SENSOR_COLS  8'h14
`define OFF_SENSOR_ROWS  8'h18
`define OFF_WIDTH_LIMIT  8'h1c
`define OFF_HEIGHT_LIMIT 8'h20
`define OFF_STATUS       8'h24
`define OFF_STAGE_EN     8'h28
`define OFF_STAGE_TRIM   8'h2c

// Field positions and reset values
`define CTRL_STREAM_EN   0
`define STAT_REJECT      0
`define STAT_FRAME       1
`define CTRL_RESET       1'h0
`define STAGE_EN_RESET   8'h00
`define STAGE_TRIM_RESET 32'h0000_0000
`define HSTART_RESET     16'h0000

`endif

// *** include/image_window_pkg.sv ***
`include "image_window_defs.svh"
`default_nettype none

package image_window_pkg;

    typedef enum logic [1:0] {
        FRAME_IDLE = 2'b01,
        FRAME_BUSY = 2'b10
    } frame_state_type;

    typedef logic [`PIX_W-1:0] pixel_type;
    typedef logic [`DIM_W-1:0] dim_type;

endpackage : image_window_pkg

`default_nettype wire

// *** rtl/correction_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "image_window_defs.svh"

module correction_stage
    import image_window_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Stage control
    input  wire logic              enable,
    input  wire logic [`TRIM_W-1:0] trim,
    // Pixel in
    input  wire logic              in_valid,
    input  wire logic              in_sof,
    input  wire logic              in_eol,
    input  wire pixel_type         in_data,
    // Pixel out
    output logic                   out_valid,
    output logic                   out_sof,
    output logic                   out_eol,
    output pixel_type              out_data
);

    // Signed trim, saturated so that a bright pixel never wraps to dark
    logic signed [`PIX_W+1:0] sum;
    pixel_type                corr_d;

    assign sum    = $signed({2'b00, in_data}) + $signed({{(`PIX_W-2){trim[`TRIM_W-1]}}, trim});
    assign corr_d = sum[`PIX_W+1] ? '0 : (sum[`PIX_W] ? '1 : sum[`PIX_W-1:0]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid <= 1'b0;
            out_sof   <= 1'b0;
            out_eol   <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            out_valid <= in_valid;
            out_sof   <= in_sof & in_valid;
            out_eol   <= in_eol & in_valid;
            out_data  <= enable ? corr_d : in_data;
        end
    end

    a_stage_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> out_data == $past(in_data))
        else $error("bypassed stage altered pixel");

endmodule : correction_stage

`default_nettype wire

// *** rtl/image_window_ctrl.sv ***
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "image_window_defs.svh"


module image_window_ctrl
    import image_window_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Full-sensor readout stream
    input  wire logic        sens_valid,
    input  wire logic        sens_sof,
    input  wire logic        sens_eol,
    input  wire pixel_type   sens_data,
    // Cropped stream to link
    output logic             out_valid,
    output logic             out_sof,
    output logic             out_eol,
    output pixel_type        out_data
);

    // Register state
    logic                    stream_en_q;
    dim_type                 width_q;
    dim_type                 height_q;
    dim_type                 hstart_q;
    logic                    reject_q;
    logic [`STAGE_NUM-1:0]   stage_en_q;
    logic [31:0]             stage_trim_q;
    frame_state_type         state_q;
    frame_state_type         state_d;

    // Window latched per frame so a change never tears a frame
    dim_type                 act_w_q;
    dim_type                 act_h_q;
    dim_type                 act_hs_q;
    dim_type                 act_vs_q;
    dim_type                 col_q;
    dim_type                 row_q;

    // APB decode
    wire access   = psel & penable;
    wire setup    = psel & ~penable;
    wire wr_en    = access & pwrite;
    wire sel_ctrl = paddr == `OFF_CTRL;
    wire sel_w    = paddr == `OFF_WIDTH;
    wire sel_h    = paddr == `OFF_HEIGHT;
    wire sel_hs   = paddr == `OFF_HSTART;
    wire sel_vs   = paddr == `OFF_VSTART;
    wire sel_sc   = paddr == `OFF_SENSOR_COLS;
    wire sel_sr   = paddr == `OFF_SENSOR_ROWS;
    wire sel_wl   = paddr == `OFF_WIDTH_LIMIT;
    wire sel_hl   = paddr == `OFF_HEIGHT_LIMIT;
    wire sel_st   = paddr == `OFF_STATUS;
    wire sel_en   = paddr == `OFF_STAGE_EN;
    wire sel_tr   = paddr == `OFF_STAGE_TRIM;
    wire sel_ro   = sel_vs | sel_sc | sel_sr | sel_wl | sel_hl;
    wire mapped   = sel_ctrl | sel_w | sel_h | sel_hs | sel_ro | sel_st | sel_en | sel_tr;

    // limits fixed at the sensor array size
    // No binning or decimation here, so the whole array is available
    dim_type width_limit;
    dim_type height_limit;
    assign width_limit  = `SENSOR_COLS;
    assign height_limit = `SENSOR_ROWS;

    // centred vertical start
    // Difference of two multiples of 8, so halving stays exact
    dim_type vstart;
    dim_type row_spare;
    assign row_spare = `SENSOR_ROWS - height_q;
    assign vstart    = {1'b0, row_spare[`DIM_W-1:1]};

    // Candidate checks on write data
    dim_type          wval;
    logic [`DIM_W:0]  w_span;
    logic [`DIM_W:0]  hs_span;
    assign wval    = pwdata[`DIM_W-1:0];
    wire   hi_zero = pwdata[31:`DIM_W] == '0;
    assign w_span  = {1'b0, wval} + {1'b0, hstart_q};
    assign hs_span = {1'b0, wval} + {1'b0, width_q};

    wire w_align = wval[`WIDTH_ALIGN_MSB:0] == '0;
    wire h_align = wval[`HEIGHT_ALIGN_MSB:0] == '0;
    wire w_min   = wval >= `MIN_WIDTH;
    wire h_min   = wval >= `MIN_HEIGHT;
    wire w_fit   = w_span <= {1'b0, width_limit};
    wire h_fit   = wval <= height_limit;
    wire hs_fit  = hs_span <= {1'b0, width_limit};
    wire w_ok    = hi_zero & w_align & w_min & w_fit;
    wire h_ok    = hi_zero & h_align & h_min & h_fit;
    wire hs_ok   = hi_zero & hs_fit;

    wire rejected = (sel_w & ~w_ok) | (sel_h & ~h_ok) | (sel_hs & ~hs_ok);
    wire bad_wr   = wr_en & rejected;
    wire ro_wr    = wr_en & sel_ro;

    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | ro_wr | bad_wr);

    // read mux for all registers; loaded in setup cycle
    wire [31:0] rd_mux =
        sel_ctrl ? {31'h0, stream_en_q} :
        sel_w    ? {16'h0000, width_q} :
        sel_h    ? {16'h0000, height_q} :
        sel_hs   ? {16'h0000, hstart_q} :
        sel_vs   ? {16'h0000, vstart} :
        sel_sc   ? {16'h0000, `SENSOR_COLS} :
        sel_sr   ? {16'h0000, `SENSOR_ROWS} :
        sel_wl   ? {16'h0000, width_limit} :
        sel_hl   ? {16'h0000, height_limit} :
        sel_st   ? {30'h0, state_q == FRAME_BUSY, reject_q} :
        sel_en   ? {24'h00_0000, stage_en_q} :
        sel_tr   ? stage_trim_q : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup & ~pwrite)
            prdata <= rd_mux;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            width_q  <= `SENSOR_COLS;
            height_q <= `SENSOR_ROWS;
            hstart_q <= `HSTART_RESET;
        end
        else if (wr_en & ~rejected)
        begin
            if (sel_w)
                width_q <= wval;
            if (sel_h)
                height_q <= wval;
            if (sel_hs)
                hstart_q <= wval;
        end
    end

    // Reject flag: a new reject wins over a clear in the same cycle
    wire reject_clr = wr_en & sel_st & pwdata[`STAT_REJECT];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reject_q <= 1'b0;
        else
            reject_q <= bad_wr | (reject_q & ~reject_clr);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stream_en_q  <= `CTRL_RESET;
            stage_en_q   <= `STAGE_EN_RESET;
            stage_trim_q <= `STAGE_TRIM_RESET;
        end
        else if (wr_en)
        begin
            if (sel_ctrl)
                stream_en_q <= pwdata[`CTRL_STREAM_EN];
            if (sel_en)
                stage_en_q <= pwdata[`STAGE_NUM-1:0];
            if (sel_tr)
                stage_trim_q <= pwdata;
        end
    end

    // correction chain in fixed order
    // Stage 0 dark offset, 1 tap linearity, 2 response, 3 defect,
    // 4 flat field, 5 white balance, 6 gain/offset, 7 mirror slot
    logic [`STAGE_NUM:0] ch_valid;
    logic [`STAGE_NUM:0] ch_sof;
    logic [`STAGE_NUM:0] ch_eol;
    pixel_type           ch_data [0:`STAGE_NUM];

    assign ch_valid[0] = sens_valid;
    assign ch_sof[0]   = sens_sof;
    assign ch_eol[0]   = sens_eol;
    assign ch_data[0]  = sens_data;

    genvar gi;
    generate
        for (gi = 0; gi < `STAGE_NUM; gi = gi + 1)
        begin : g_stage
            correction_stage u_stage (
                .pclk      (pclk),
                .presetn   (presetn),
                .enable    (stage_en_q[gi]),
                .trim      (stage_trim_q[gi*`TRIM_W +: `TRIM_W]),
                .in_valid  (ch_valid[gi]),
                .in_sof    (ch_sof[gi]),
                .in_eol    (ch_eol[gi]),
                .in_data   (ch_data[gi]),
                .out_valid (ch_valid[gi+1]),
                .out_sof   (ch_sof[gi+1]),
                .out_eol   (ch_eol[gi+1]),
                .out_data  (ch_data[gi+1])
            );
        end
    endgenerate

    // Cropping on the corrected full frame keeps full-sensor quality
    wire       c_valid = ch_valid[`STAGE_NUM];
    wire       c_sof   = ch_sof[`STAGE_NUM] & c_valid;
    wire       c_eol   = ch_eol[`STAGE_NUM] & c_valid;

    // coordinates start at (0, 0) on frame start
    dim_type cur_col;
    dim_type cur_row;
    assign cur_col = c_sof ? '0 : col_q;
    assign cur_row = c_sof ? '0 : row_q;

    // Live settings apply from the first pixel of a frame
    dim_type win_w;
    dim_type win_h;
    dim_type win_hs;
    dim_type win_vs;
    assign win_w  = c_sof ? width_q  : act_w_q;
    assign win_h  = c_sof ? height_q : act_h_q;
    assign win_hs = c_sof ? hstart_q : act_hs_q;
    assign win_vs = c_sof ? vstart   : act_vs_q;

    logic [`DIM_W:0] x_end;
    logic [`DIM_W:0] y_end;
    dim_type         x_last;
    assign x_end  = {1'b0, win_hs} + {1'b0, win_w};
    assign y_end  = {1'b0, win_vs} + {1'b0, win_h};
    assign x_last = x_end[`DIM_W-1:0] - 16'h0001;

    wire in_x   = (cur_col >= win_hs) & ({1'b0, cur_col} < x_end);
    wire in_y   = (cur_row >= win_vs) & ({1'b0, cur_row} < y_end);
    wire in_win = c_valid & in_x & in_y & stream_en_q;
    wire row_end = c_eol & (cur_row == `SENSOR_ROWS - 16'h0001);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            col_q    <= '0;
            row_q    <= '0;
            act_w_q  <= `SENSOR_COLS;
            act_h_q  <= `SENSOR_ROWS;
            act_hs_q <= `HSTART_RESET;
            act_vs_q <= '0;
        end
        else if (c_valid)
        begin
            col_q    <= c_eol ? '0 : cur_col + 16'h0001;
            row_q    <= c_eol ? cur_row + 16'h0001 : cur_row;
            act_w_q  <= win_w;
            act_h_q  <= win_h;
            act_hs_q <= win_hs;
            act_vs_q <= win_vs;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid <= 1'b0;
            out_sof   <= 1'b0;
            out_eol   <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            out_valid <= in_win;
            out_sof   <= in_win & (cur_col == win_hs) & (cur_row == win_vs);
            out_eol   <= in_win & (cur_col == x_last);
            out_data  <= ch_data[`STAGE_NUM];
        end
    end

    // Frame tracking for status
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            FRAME_IDLE: if (c_sof) state_d = FRAME_BUSY;
            FRAME_BUSY: if (row_end) state_d = FRAME_IDLE;
            default:    state_d = FRAME_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= FRAME_IDLE;
        else
            state_q <= state_d;
    end

    // Assertion helpers
    logic    seen_q;
    dim_type ocnt_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_q <= 1'b0;
            ocnt_q <= '0;
        end
        else
        begin
            seen_q <= 1'b1;
            if (out_valid)
                ocnt_q <= out_eol ? '0 : ocnt_q + 16'h0001;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cols_setup;
        psel && !penable && !pwrite && paddr == `OFF_SENSOR_COLS;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    a_sensor_ro_read: assert property (
        s_cols_setup ##1 s_access |-> prdata == {16'h0000, `SENSOR_COLS})
        else $error("sensor columns read wrong");
    a_ro_write_err: assert property (
        wr_en && sel_ro |-> pslverr)
        else $error("read-only write not flagged");
    a_reject_keeps: assert property (
        wr_en && sel_w && !w_ok |=> width_q == $past(width_q) && reject_q)
        else $error("invalid width took effect");
    a_width_align: assert property (
        width_q[`WIDTH_ALIGN_MSB:0] == '0)
        else $error("width not aligned");
    a_height_align: assert property (
        height_q[`HEIGHT_ALIGN_MSB:0] == '0)
        else $error("height not aligned");
    a_min_size: assert property (
        width_q >= `MIN_WIDTH && height_q >= `MIN_HEIGHT)
        else $error("window below minimum");
    a_vstart_centre: assert property (
        $changed(height_q) |-> (vstart + vstart + height_q) == `SENSOR_ROWS)
        else $error("vertical start not centred");
    a_reset_full: assert property (
        !seen_q |-> width_q == width_limit && height_q == height_limit)
        else $error("window not full after reset");
    a_line_width: assert property (
        out_valid && out_eol |-> ocnt_q == act_w_q - 16'h0001)
        else $error("output line length wrong");
    a_origin_start: assert property (
        out_sof |-> $past(cur_col) == act_hs_q && $past(cur_row) == act_vs_q)
        else $error("window start misplaced");

endmodule : image_window_ctrl

`default_nettype wire

// *** verif/link_sink_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "image_window_defs.svh"

module link_sink_model
    import image_window_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Cropped stream from the camera
    input  wire logic        valid,
    input  wire logic        sof,
    input  wire logic        eol,
    input  wire pixel_type   data,
    // Tallies for the bench
    output logic [31:0]      n_pix,
    output logic [31:0]      n_sof,
    output logic [31:0]      n_eol,
    output logic [31:0]      sum,
    output pixel_type        first_data
);

    // Grabber has no back-pressure, so it just tallies every delivered pixel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            n_pix      <= 32'h0000_0000;
            n_sof      <= 32'h0000_0000;
            n_eol      <= 32'h0000_0000;
            sum        <= 32'h0000_0000;
            first_data <= 12'h000;
        end
        else if (valid)
        begin
            n_pix <= n_pix + 32'h1;
            n_sof <= n_sof + {31'h0, sof};
            n_eol <= n_eol + {31'h0, eol};
            sum   <= sum + {20'h0, data};
            if (sof)
                first_data <= data;
        end
    end

endmodule : link_sink_model
`default_nettype wire

// *** verif/image_window_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "image_window_defs.svh"

module image_window_ctrl_tb
    import image_window_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, n_pix, n_sof, n_eol, sum;
    logic        sens_valid, sens_sof, sens_eol, out_valid, out_sof, out_eol;
    pixel_type   sens_data, out_data, first_data;
    int          errors, n_compared;

    image_window_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .sens_valid(sens_valid), .sens_sof(sens_sof),
        .sens_eol(sens_eol), .sens_data(sens_data), .out_valid(out_valid),
        .out_sof(out_sof), .out_eol(out_eol), .out_data(out_data));

    link_sink_model grabber (.pclk(pclk), .presetn(presetn), .valid(out_valid),
        .sof(out_sof), .eol(out_eol), .data(out_data), .n_pix(n_pix), .n_sof(n_sof),
        .n_eol(n_eol), .sum(sum), .first_data(first_data));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer; waits on pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            errors++;
            $display("mismatch at %0t: pready never came", $time);
            report_and_stop();
        end
        else
        begin
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err_exp);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, err_exp}, "write error response");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp, "read data");
        chk({31'h0, e}, {31'h0, err_exp}, "read error response");
    endtask : rd

    // Marker pixel at the window's first column probes stage order
    task automatic send_rows(input int rows);
        for (int r = 0; r < rows; r++)
            for (int c = 0; c < 1024; c++)
            begin
                @(posedge pclk);
                sens_valid <= 1'b1;
                sens_sof   <= (r == 0 && c == 0);
                sens_eol   <= (c == 1023);
                sens_data  <= (c == 32) ? 12'hfff : c[11:0];
            end
        @(posedge pclk);
        sens_valid <= 1'b0;
        sens_sof   <= 1'b0;
        sens_eol   <= 1'b0;
    endtask : send_rows

    logic [7:0]  bad_a [7] = '{`OFF_WIDTH, `OFF_WIDTH, `OFF_WIDTH, `OFF_HEIGHT, `OFF_HEIGHT,
                               `OFF_HEIGHT, `OFF_HSTART};
    logic [31:0] bad_d [7] = '{32'h50, 32'h20, 32'h420, 32'hc, 32'h8, 32'h208, 32'h20};
    logic [31:0] bad_k [7] = '{32'h400, 32'h400, 32'h400, 32'h200, 32'h200, 32'h200, 32'h0};
    logic [7:0]  ro_a [6] = '{`OFF_WIDTH, `OFF_HEIGHT, `OFF_SENSOR_COLS, `OFF_SENSOR_ROWS,
                              `OFF_WIDTH_LIMIT, `OFF_HEIGHT_LIMIT};
    logic [31:0] ro_d [6] = '{32'h400, 32'h200, 32'h400, 32'h200, 32'h400, 32'h200};
    logic [31:0] exp_sum;

    initial
    begin
        errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, sens_valid, sens_sof, sens_eol} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sens_data = 12'h000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;

        for (int i = 0; i < 6; i++)
            rd(ro_a[i], ro_d[i], 1'b0);
        rd(`OFF_VSTART, 32'h0, 1'b0);
        for (int i = 2; i < 6; i++)
        begin
            wr(ro_a[i], 32'h0, 1'b1);
            rd(ro_a[i], ro_d[i], 1'b0);
        end
        $display("test reset values and read-only fields done");

        for (int i = 0; i < 7; i++)
        begin
            wr(bad_a[i], bad_d[i], 1'b1);
            rd(bad_a[i], bad_k[i], 1'b0);
        end
        rd(`OFF_STATUS, 32'h1, 1'b0);
        wr(`OFF_STATUS, 32'h1, 1'b0);
        rd(`OFF_STATUS, 32'h0, 1'b0);
        rd(8'h30, 32'h0, 1'b1);
        $display("test window rejection done");

        // Host sets size before offset, keeping the sum in bounds
        wr(`OFF_WIDTH, 32'h40, 1'b0);
        wr(`OFF_HEIGHT, 32'h1f0, 1'b0);
        wr(`OFF_HSTART, 32'h20, 1'b0);
        rd(`OFF_HSTART, 32'h20, 1'b0);
        rd(`OFF_VSTART, 32'h8, 1'b0);
        wr(`OFF_WIDTH, 32'h3e0, 1'b0);
        wr(`OFF_WIDTH, 32'h40, 1'b0);
        // Earlier stage trims rewritten with every stage change
        wr(`OFF_STAGE_EN, 32'h3, 1'b0);
        wr(`OFF_STAGE_TRIM, 32'h87, 1'b0);
        wr(`OFF_CTRL, 32'h1, 1'b0);
        $display("test window setup done");

        send_rows(10);
        repeat (20) @(posedge pclk);
        exp_sum = 32'd4087;
        for (int c = 33; c < 96; c++)
            exp_sum += c - 1;
        exp_sum = exp_sum * 2;
        chk(n_pix, 32'd128, "cropped pixel count");
        chk(n_sof, 32'd1, "frame start count");
        chk(n_eol, 32'd2, "line end count");
        chk({20'h0, first_data}, 32'd4087, "first pixel after stages");
        chk(sum, exp_sum, "cropped pixel sum");
        rd(`OFF_STATUS, 32'h2, 1'b0);
        $display("test cropped stream done");

        wr(`OFF_CTRL, 32'h0, 1'b0);
        send_rows(10);
        repeat (20) @(posedge pclk);
        chk(n_pix, 32'd128, "pixels with stream off");
        $display("test stream disable done");
        report_and_stop();
    end

endmodule : image_window_ctrl_tb
`default_nettype wire
